// ==== bench/dac_host_model.sv ====
// host model: apb master, one transfer per call
// assumes pready comes before the bench timeout
module dac_host_model (
  input wire logic pclk, pready, pslverr,
  input wire logic [31:0] prdata,
  output logic psel = '0, penable = '0, pwrite = '0,
  output logic [11:0] paddr = '0,
  output logic [31:0] pwdata = '0
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic xfer(logic w, logic [11:0] a, logic [31:0] d, output logic [32:0] r);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    r = {pslverr, prdata};
    psel <= 1'h0;
    penable <= 1'h0;
    // released data must not keep the last word
    pwdata <= ~d;
  endtask
endmodule

// ==== bench/dac_output_state_control_tb_top.sv ====
// bench: host model drives apb, checker bound to the block
module dac_output_state_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, clk_en = 1, psel, penable, pwrite, pready, pslverr;
  logic t, c, f, rc, nm;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [17:0] code;
  int fail_count, checks_done;
  always #2.5 pclk = ~pclk;
  dac_host_model host_u (.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr,
    .pwdata);
  dac_output_state_control dut_u (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .converter_tristate_bit(t), .output_clamp_bit(c),
    .feedback_resistor_select(f), .refs_connected(rc), .output_normal(nm), .dac_code(code));
  task automatic chk(string n, logic [32:0] e, logic [32:0] s);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic st(logic [4:0] e);
    @(negedge pclk);
    chk("state", 33'(e), 33'({nm, rc, f, c, t}));
  endtask
  task automatic rw(logic w, logic [11:0] a, logic [31:0] d, logic [32:0] e);
    logic [32:0] r;
    host_u.xfer(w, a, d, r);
    if (!w) chk("read", e, r);
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    st(5'h03);
    rw(1'h0, 12'h00C, 32'h0, 33'h2);
    rw(1'h0, 12'h008, 32'h0, 33'h0);
    for (int i = 0; i < 8; i++) begin
      rw(1'h1, 12'h000, 32'(i), 33'h0);
      st({i[1:0] == 2'h0, !i[0], i[2:0]});
      rw(1'h0, 12'h00C, 32'h0, i[1] ? 33'h2 : 33'(i[0]));
    end
    rw(1'h1, 12'h008, 32'h3FFFF, 33'h0);
    clk_en <= 1'h0;
    repeat (4) @(posedge pclk);
    clk_en <= 1'h1;
    rw(1'h0, 12'h008, 32'h0, 33'h3FFFF);
    rw(1'h0, 12'h010, 32'h0, 33'h100000000);
    st(5'h07);
    rw(1'h1, 12'h004, 32'h1, 33'h0);
    st(5'h03);
    rw(1'h1, 12'h000, 32'h4, 33'h0);
    st(5'h1C);
    chk("code", 33'h0, 33'(code));
    print_verdict;
  end
  initial begin
    #20000;
    fail_count++;
    print_verdict;
  end
endmodule

// ==== bench/dac_state_asserts.sv ====
// checker on the output state block ports
// assumes bind to dac_output_state_control
module dac_state_asserts (
  // watched ports
  input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic converter_tristate_bit, output_clamp_bit, feedback_resistor_select,
  input wire logic refs_connected, output_normal,
  input wire logic [17:0] dac_code
);
  wire logic w = psel && penable && pready && pwrite && !pslverr;
  wire logic wc = w && paddr == 12'h000;
  wire logic ws = w && paddr == 12'h004 && pwdata[0];
  wire logic [2:0] b = {feedback_resistor_select, output_clamp_bit, converter_tristate_bit};
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_por; $rose(presetn) |-> b == 3'h3; endproperty
  a_por: assert property (p_por) else $error("bad defaults");
  property p_off; $rose(presetn) |-> !refs_connected && !output_normal; endproperty
  a_off: assert property (p_off) else $error("bad power-on");
  property p_code; $rose(presetn) |-> dac_code == 18'h00000; endproperty
  a_code: assert property (p_code) else $error("bad code");
  property p_hold; !wc && !ws |=> $stable(b); endproperty
  a_hold: assert property (p_hold) else $error("bits moved");
  property p_wr; wc |=> b == $past(pwdata[2:0]); endproperty
  a_wr: assert property (p_wr) else $error("bits not taken");
  property p_nm; output_normal == (b[1:0] == 2'h0); endproperty
  a_nm: assert property (p_nm) else $error("bad normal");
  property p_tri; converter_tristate_bit |-> !refs_connected; endproperty
  a_tri: assert property (p_tri) else $error("refs on");
  property p_sw; ws |=> b == 3'h3 && dac_code == 18'h00000; endproperty
  a_sw: assert property (p_sw) else $error("bad soft reset");
endmodule
bind dac_output_state_control dac_state_asserts chk_u (.*);

// ==== logic/dac_output_state_control.sv ====
// apb-controlled converter output state, clamp and feedback select
// assumes pclk domain inputs; analog switches follow the registered outputs
//
// Added by the designer: register access over APB and the address map.
module dac_output_state_control (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog controls
  output logic converter_tristate_bit,
  output logic output_clamp_bit,
  output logic feedback_resistor_select,
  output logic refs_connected,
  output logic output_normal,
  output logic [17:0] dac_code
);
  // control bits and their next values
  logic tri_q;
  logic tri_d;
  logic clamp_q;
  logic clamp_d;
  logic fb_q;
  logic fb_d;

  // data register
  logic [17:0] data_q;
  logic [17:0] data_d;

  // bus response next values
  logic [31:0] prdata_d;
  logic pready_d;
  logic pslverr_d;

  // analog status next values
  logic refs_d;
  logic norm_d;
  dac_state_pkg::out_state_e st_now;
  dac_state_pkg::out_state_e st_next;

  // qualified bus events
  logic access;
  logic hit;
  logic wr;
  logic rd;
  logic ctrl_wr;
  logic data_wr;
  logic swrst_wr;

  // state from the next values keeps the outputs flop-driven and aligned
  dac_state_decode u_dec_next (
    .tri_bit(tri_d),
    .clamp_bit(clamp_d),
    .state(st_next)
  );

  // state of the bits now, for the status read
  dac_state_decode u_dec_now (
    .tri_bit(tri_q),
    .clamp_bit(clamp_q),
    .state(st_now)
  );

  function automatic logic addr_known(input logic [11:0] a);
    addr_known = (a == dac_state_pkg::ctrl_addr) || (a == dac_state_pkg::swctl_addr) ||
                 (a == dac_state_pkg::data_addr) || (a == dac_state_pkg::status_addr);
  endfunction

  // unused bits of the control word read as zero
  function automatic logic [31:0] ctrl_word(input logic t, input logic c, input logic f);
    ctrl_word = 32'h00000000;
    ctrl_word[dac_state_pkg::tri_pos] = t;
    ctrl_word[dac_state_pkg::clamp_pos] = c;
    ctrl_word[dac_state_pkg::fbsel_pos] = f;
  endfunction

  function automatic logic [31:0] status_word(input dac_state_pkg::out_state_e s);
    status_word = 32'h00000000;
    status_word[1:0] = s;
  endfunction

  // one wait state: answer in the cycle after the access phase begins
  assign access = psel && penable;
  assign hit = addr_known(paddr);
  // a write lands only at the edge where the registered pready is high
  assign wr = access && pready && pwrite && hit;
  assign rd = access && !pwrite && !pready;
  assign ctrl_wr = wr && (paddr == dac_state_pkg::ctrl_addr);
  assign data_wr = wr && (paddr == dac_state_pkg::data_addr);
  assign swrst_wr = wr && (paddr == dac_state_pkg::swctl_addr) &&
                    pwdata[dac_state_pkg::swrst_pos];

  // control bits
  always_comb begin
    tri_d = tri_q;
    clamp_d = clamp_q;
    fb_d = fb_q;
    if (swrst_wr) begin
      tri_d = dac_state_pkg::tri_rst;
      clamp_d = dac_state_pkg::clamp_rst;
      fb_d = dac_state_pkg::fbsel_rst;
    end else if (ctrl_wr) begin
      tri_d = pwdata[dac_state_pkg::tri_pos];
      clamp_d = pwdata[dac_state_pkg::clamp_pos];
      fb_d = pwdata[dac_state_pkg::fbsel_pos];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tri_q <= dac_state_pkg::tri_rst;
      clamp_q <= dac_state_pkg::clamp_rst;
      fb_q <= dac_state_pkg::fbsel_rst;
    end else if (clk_en) begin
      tri_q <= tri_d;
      clamp_q <= clamp_d;
      fb_q <= fb_d;
    end
  end

  // data register
  always_comb begin
    data_d = data_q;
    if (swrst_wr) begin
      data_d = dac_state_pkg::data_rst;
    end else if (data_wr) begin
      data_d = pwdata[17:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_q <= dac_state_pkg::data_rst;
    end else if (clk_en) begin
      data_q <= data_d;
    end
  end

  // references stay cut while the tristate bit is set, clamped or not,
  // so the power-on condition keeps them off until the host clears it
  always_comb begin
    refs_d = !tri_d;
    norm_d = (st_next == dac_state_pkg::st_normal);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refs_connected <= 1'b0;
      output_normal <= 1'b0;
    end else if (clk_en) begin
      refs_connected <= refs_d;
      output_normal <= norm_d;
    end
  end

  // bus response: pready is a one-cycle pulse, prdata valid with it
  always_comb begin
    prdata_d = 32'h00000000;
    pready_d = 1'b0;
    pslverr_d = 1'b0;
    if (access && !pready) begin
      pready_d = 1'b1;
      pslverr_d = !hit;
    end
    if (rd && paddr == dac_state_pkg::ctrl_addr) begin
      prdata_d = ctrl_word(tri_q, clamp_q, fb_q);
    end else if (rd && paddr == dac_state_pkg::data_addr) begin
      prdata_d[17:0] = data_q;
    end else if (rd && paddr == dac_state_pkg::status_addr) begin
      prdata_d = status_word(st_now);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // analog switch controls come straight from the registered bits
  assign converter_tristate_bit = tri_q;
  assign output_clamp_bit = clamp_q;
  assign feedback_resistor_select = fb_q;
  assign dac_code = data_q;

endmodule

// ==== logic/dac_state_decode.sv ====
// output state decoder for the converter
// takes the registered tristate and clamp bits, or their next values, at its inputs
module dac_state_decode (
  // control bits
  input wire logic tri_bit,
  input wire logic clamp_bit,
  // decoded state
  output dac_state_pkg::out_state_e state
);
  always_comb begin
    if (clamp_bit) begin
      state = dac_state_pkg::st_clamped;
    end else if (tri_bit) begin
      state = dac_state_pkg::st_tristate;
    end else begin
      state = dac_state_pkg::st_normal;
    end
  end
endmodule

// ==== logic/dac_state_pkg.sv ====
// constants for the converter output state control block
// assumes an apb slave on pclk, 32-bit data, word-aligned registers
package dac_state_pkg;
  localparam logic [11:0] ctrl_addr = 12'h000;
  localparam logic [11:0] swctl_addr = 12'h004;
  localparam logic [11:0] data_addr = 12'h008;
  localparam logic [11:0] status_addr = 12'h00C;
  localparam int tri_pos = 0;
  localparam int clamp_pos = 1;
  localparam int fbsel_pos = 2;
  localparam int swrst_pos = 0;
  localparam int data_w = 18;
  localparam logic tri_rst = 1'h1;
  localparam logic clamp_rst = 1'h1;
  localparam logic fbsel_rst = 1'h0;
  // data default: code that puts the output at the negative reference
  localparam logic [17:0] data_rst = 18'h00000;
  typedef enum logic [1:0] {st_normal, st_tristate, st_clamped} out_state_e;
endpackage
